//--- acr_adc_control_regs_bench.sv
// bench: register, interrupt and conversion scenarios
`timescale 1ns/1ns
module acr_adc_control_regs_bench;
	logic        clk, reset_n, wr, rd, comp_in;
	logic [7:0]  addr, wdata, rdata, v;
	logic [15:0] chan_select;
	logic        adc_enable, ref_external, sample, conv_tick, irq;
	logic [11:0] target, last;
	int          error_cnt, cmp_count, seed, i;
	acr_adc_control_regs acr_adc_control_regs_i (.clk, .reset_n, .addr,
		.wdata, .wr, .rd, .rdata, .adc_enable, .chan_select, .ref_external,
		.sample, .conv_tick, .comp_in, .irq);
	acr_analog_model acr_analog_model_i (.clk, .reset_n, .sample,
		.conv_tick, .target, .comp_in);
	function automatic logic [15:0] hot(input logic [3:0] c);
		return (c == 4'hd || c == 4'he) ? 16'h0000 : 16'h0001 << c;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rreg(input logic [7:0] a, output logic [7:0] d);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rreg(a, d);
		chk(d, exp);
	endtask
	task automatic conv(input logic [2:0] dv, input logic [11:0] t,
		input logic ab);
		target <= t;
		wreg(8'h21, {4'h0, dv, 1'b0});
		wreg(8'h20, 8'h80);
		wreg(8'h20, 8'hc0);
		rchk(8'h20, 8'h80);
		if (ab) begin
			wreg(8'h20, 8'h00);
			rchk(8'h22, last[11:4]);
			rchk(8'h28, 8'h00);
			return;
		end
		v = 8'h00;
		for (int n = 0; n < 300 && v[6] !== 1'b1; n++)
			rreg(8'h20, v);
		chk(v, 8'hc0);
		rchk(8'h22, t[11:4]);
		rchk(8'h23, {t[3:0], 4'h0});
		wreg(8'h22, ~t[11:4]);
		wreg(8'h23, 8'h5a);
		rchk(8'h22, t[11:4]);
		rchk(8'h28, 8'h01);
		last = t;
	endtask
	task automatic end_sim();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200_000;
		error_cnt++;
		end_sim();
	end
	initial begin
		{reset_n, wr, rd, addr, wdata, target} = '0;
		seed = 5131;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rchk(8'h20, 8'h40);
		rchk(8'h21, 8'h00);
		rchk(8'h30, 8'h00);
		for (i = 0; i < 16; i++) begin
			wreg(8'h20, {2'b00, i[3:0], 2'b00});
			chk(chan_select, hot(i[3:0]));
		end
		for (i = 0; i < 8; i++) begin
			wreg(8'h21, {4'h0, i[2:0], 1'b0});
			rchk(8'h21, {4'h0, i[2:0], 1'b0});
		end
		wreg(8'h24, 8'h80);
		chk(ref_external, 1'b1);
		rchk(8'h24, 8'h00);
		wreg(8'h24, 8'h00);
		chk(ref_external, 1'b0);
		wreg(8'h29, 8'h01);
		wreg(8'h20, 8'h40);
		chk(irq, 1'b0);
		wreg(8'h29, 8'h03);
		chk(irq, 1'b1);
		rchk(8'h28, 8'h02);
		chk(irq, 1'b0);
		conv(3'd2, 12'h800, 1'b0);
		conv(3'd3, 12'hfff, 1'b0);
		conv(3'd2, 12'h001, 1'b0);
		for (i = 0; i < 8; i++)
			conv(3'(2 + {$random(seed)} % 3), 12'($random(seed)), i == 5);
		end_sim();
	end
endmodule
bind acr_adc_control_regs acr_monitor #(.CONV_CLOCKS(CONV_CLOCKS))
	acr_monitor_i (.*);

//--- acr_analog_model.sv
// partner: ideal comparator of the analog core, answers msb first
`timescale 1ns/1ns
module acr_analog_model (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// converter core side
	input wire logic        sample,
	input wire logic        conv_tick,
	input wire logic [11:0] target,
	output logic            comp_in
);
	logic [3:0] idx_r;
	logic       tog_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idx_r <= 4'hb;
			tog_r <= 1'b0;
		end else begin
			tog_r <= !tog_r;
			if (sample)
				idx_r <= 4'hb;
			else if (conv_tick && idx_r != 4'h0)
				idx_r <= idx_r - 4'h1;
		end
	end
	// msb answer stands from the end of sampling; a changing pattern before
	assign comp_in = sample ? tog_r : target[idx_r];
endmodule

//--- acr_monitor.sv
// checker: port-level properties of the converter control block
`timescale 1ns/1ns
module acr_monitor #(
	parameter int CONV_CLOCKS = 14
) (
	// clock, reset and register port
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [7:0]  addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [7:0]  rdata,
	// analog core and interrupt
	input wire logic        adc_enable,
	input wire logic [15:0] chan_select,
	input wire logic        ref_external,
	input wire logic        sample,
	input wire logic        conv_tick,
	input wire logic        comp_in,
	input wire logic        irq
);
	logic       ctl_wr;
	logic [2:0] mode_r;
	assign ctl_wr = wr && addr == acr_pkg::ADDR_CONTROL;
	// shadow of the divider code, to know the tick spacing
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			mode_r <= 3'h0;
		else if (wr && addr == acr_pkg::ADDR_CLOCK_MODE)
			mode_r <= wdata[3:1];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_ENABLE: assert property (ctl_wr |=> adc_enable == $past(wdata[7]))
		else $error("enable bit not taken");
	AST_IDLE_OFF: assert property (!adc_enable |-> !conv_tick && !sample)
		else $error("activity while disabled");
	AST_CHAN: assert property (ctl_wr && !(wdata[5:2] inside {4'hd, 4'he})
		|=> chan_select == 16'h0001 << $past(wdata[5:2]))
		else $error("channel decode wrong");
	AST_RESV: assert property (ctl_wr && wdata[5:2] inside {4'hd, 4'he}
		|=> chan_select == 16'h0000) else $error("reserved code selects");
	AST_LONIB: assert property (rd && addr == acr_pkg::ADDR_RESULT_LO
		|=> rdata[3:0] == 4'h0) else $error("low nibble not zero");
	AST_REF: assert property (wr && addr == acr_pkg::ADDR_REF_SEL
		|=> ref_external == $past(wdata[7])) else $error("reference not taken");
	AST_IGNORED: assert property (ctl_wr && wdata[6] && !adc_enable
		|=> !sample ##1 !sample) else $error("start while disabled");
	AST_DIV: assert property (conv_tick && mode_r == 3'd2
		|=> !conv_tick [*3]) else $error("tick spacing wrong");
endmodule

//--- adc_clk_div.sv
// module: power-of-two converter clock enable divider
`timescale 1ns/1ns
module acr_clk_div #(
	parameter int DIV_BITS = 3
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset_n,
	// control
	input  wire logic                run,
	input  wire logic [DIV_BITS-1:0] div_code,
	// tick out
	output logic                     tick
);
	localparam int CNT_W = (1 << DIV_BITS) - 1;

	initial begin
		if (DIV_BITS < 1 || DIV_BITS > 8)
			$error("acr_clk_div: DIV_BITS out of range");
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} acr_div_s;

	acr_div_s st_r;
	acr_div_s st_nxt;
	logic [CNT_W-1:0] mask;

	// ------------------------------------------------------------
	// divide by two to the power of the code
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		mask = CNT_W'((1 << div_code) - 1);
		tick = run && ((st_r.cnt & mask) == '0);
		if (!run)
			st_nxt.cnt = '0;
		else
			st_nxt.cnt = st_r.cnt + 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
endmodule

//--- adc_control_regs.sv
// module: converter control registers, sequencer and result capture
`timescale 1ns/1ns
module acr_adc_control_regs #(
	parameter int CONV_CLOCKS = acr_pkg::CONV_CLOCKS
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// register port
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	// analog core
	output logic             adc_enable,
	output logic [15:0]      chan_select,
	output logic             ref_external,
	output logic             sample,
	output logic             conv_tick,
	input  wire logic        comp_in,
	// interrupt
	output logic             irq
);
	initial begin
		if (CONV_CLOCKS < acr_pkg::RESULT_BITS || CONV_CLOCKS > 255)
			$error("acr_adc_control_regs: CONV_CLOCKS out of range");
	end

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_CONV   = 3'b100
	} acr_state_e;

	typedef struct packed {
		acr_state_e                      state;
		logic                            enable;
		logic [3:0]                      chan;
		logic [2:0]                      div;
		logic                            ref_ext;
		logic [acr_pkg::RESULT_BITS-1:0] result;
		logic [acr_pkg::RESULT_BITS-1:0] sar;
		logic [7:0]                      clocks;
		logic [1:0]                      irq_stat;
		logic [1:0]                      irq_mask;
		logic [7:0]                      rdata;
		logic                            cmp_s1;
		logic                            cmp_s2;
	} acr_regs_s;

	acr_regs_s st_r;
	acr_regs_s st_nxt;
	logic      tick;
	logic      running;

	// ------------------------------------------------------------
	// channel decode, one line per code; codes 4'hd and 4'he select no line
	// ------------------------------------------------------------
	function automatic logic [15:0] chan_decode(input logic [3:0] code);
		logic [15:0] onehot;
		onehot = '0;
		if (code <= acr_pkg::CHAN_LAST_PIN || code == acr_pkg::CHAN_BANDGAP)
			onehot[code] = 1'b1;
		return onehot;
	endfunction

	function automatic logic is_write(input logic [7:0] a, input logic w,
		input logic [7:0] target);
		return w && (a == target);
	endfunction

	assign running = (st_r.state != ST_IDLE);

	acr_clk_div #(
		.DIV_BITS (acr_pkg::DIV_BITS)
	) u_div (
		.clk      (clk),
		.reset_n  (reset_n),
		.run      (running),
		.div_code (st_r.div),
		.tick     (tick)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [acr_pkg::RESULT_BITS-1:0] bitpos;
		logic [acr_pkg::RESULT_BITS-1:0] trial;
		logic [1:0] ev;
		bitpos = '0;
		trial = '0;
		ev = '0;
		st_nxt = st_r;
		st_nxt.cmp_s1 = comp_in;
		st_nxt.cmp_s2 = st_r.cmp_s1;

		// register writes
		if (is_write(addr, wr, acr_pkg::ADDR_CONTROL)) begin
			st_nxt.enable = wdata[acr_pkg::CTL_ENABLE_BIT];
			st_nxt.chan = wdata[acr_pkg::CTL_CHAN_LSB +: 4];
		end
		if (is_write(addr, wr, acr_pkg::ADDR_CLOCK_MODE))
			st_nxt.div = wdata[acr_pkg::MODE_DIV_LSB +: acr_pkg::DIV_BITS];
		if (is_write(addr, wr, acr_pkg::ADDR_REF_SEL))
			st_nxt.ref_ext = wdata[acr_pkg::REF_EXT_BIT];
		if (is_write(addr, wr, acr_pkg::ADDR_IRQ_MASK))
			st_nxt.irq_mask = wdata[1:0];
		// result bytes have no write decode at all
		st_nxt.result = st_r.result;

		// conversion sequencer
		case (st_r.state)
			ST_IDLE: begin
				if (is_write(addr, wr, acr_pkg::ADDR_CONTROL)
					&& wdata[acr_pkg::CTL_START_BIT]) begin
					if (wdata[acr_pkg::CTL_ENABLE_BIT] && st_r.enable) begin
						st_nxt.state = ST_SAMPLE;
						st_nxt.clocks = '0;
						st_nxt.sar = '0;
					end else begin
						ev[acr_pkg::IRQ_IGNORED_BIT] = 1'b1;
					end
				end
			end
			ST_SAMPLE: begin
				if (!st_nxt.enable)
					st_nxt.state = ST_IDLE;
				else if (tick) begin
					st_nxt.clocks = st_r.clocks + 8'h01;
					if (st_r.clocks == 8'(CONV_CLOCKS - acr_pkg::RESULT_BITS)) begin
						st_nxt.state = ST_CONV;
						st_nxt.clocks = '0;
						st_nxt.sar = {1'b1, {(acr_pkg::RESULT_BITS-1){1'b0}}};
					end
				end
			end
			ST_CONV: begin
				if (!st_nxt.enable)
					st_nxt.state = ST_IDLE;
				else if (tick) begin
					// one bit per converter clock, msb first
					bitpos = {1'b1, {(acr_pkg::RESULT_BITS-1){1'b0}}}
						>> st_r.clocks;
					trial = st_r.sar;
					if (!st_r.cmp_s2)
						trial = trial & ~bitpos;
					if (st_r.clocks == 8'(acr_pkg::RESULT_BITS - 1)) begin
						st_nxt.result = trial;
						st_nxt.state = ST_IDLE;
						ev[acr_pkg::IRQ_DONE_BIT] = 1'b1;
					end else begin
						st_nxt.sar = trial | (bitpos >> 1);
						st_nxt.clocks = st_r.clocks + 8'h01;
					end
				end
			end
			default: st_nxt.state = ST_IDLE;
		endcase

		// read data, one cycle later
		st_nxt.rdata = 8'h00;
		if (rd) begin
			case (addr)
				acr_pkg::ADDR_CONTROL:
					st_nxt.rdata = {st_r.enable, !running, st_r.chan, 2'b00};
				acr_pkg::ADDR_CLOCK_MODE:
					st_nxt.rdata = {4'h0, st_r.div, 1'b0};
				acr_pkg::ADDR_RESULT_HI:
					st_nxt.rdata = st_r.result[11:4];
				acr_pkg::ADDR_RESULT_LO:
					st_nxt.rdata = {st_r.result[3:0], 4'h0};
				acr_pkg::ADDR_IRQ_STATUS:
					st_nxt.rdata = {6'h00, st_r.irq_stat};
				acr_pkg::ADDR_IRQ_MASK:
					st_nxt.rdata = {6'h00, st_r.irq_mask};
				default:
					st_nxt.rdata = 8'h00;
			endcase
		end

		// sticky status: read clears, new event wins
		if (rd && addr == acr_pkg::ADDR_IRQ_STATUS)
			st_nxt.irq_stat = ev;
		else
			st_nxt.irq_stat = st_r.irq_stat | ev;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r.state    <= ST_IDLE;
			st_r.enable   <= 1'b0;
			st_r.chan     <= acr_pkg::CHAN_RESET;
			st_r.div      <= acr_pkg::DIV_RESET;
			st_r.ref_ext  <= 1'b0;
			st_r.result   <= '0;
			st_r.sar      <= '0;
			st_r.clocks   <= '0;
			st_r.irq_stat <= acr_pkg::IRQ_RESET;
			st_r.irq_mask <= acr_pkg::IRQ_RESET;
			st_r.rdata    <= 8'h00;
			st_r.cmp_s1   <= 1'b0;
			st_r.cmp_s2   <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign rdata        = st_r.rdata;
	assign adc_enable   = st_r.enable;
	assign chan_select  = chan_decode(st_r.chan);
	assign ref_external = st_r.ref_ext;
	assign sample       = (st_r.state == ST_SAMPLE);
	assign conv_tick    = tick;
	assign irq          = |(st_r.irq_stat & st_r.irq_mask);
endmodule

//--- adc_pkg.sv
// package: register map, field layout and constants for converter control
package acr_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL    = 8'h20;
	localparam logic [7:0] ADDR_CLOCK_MODE = 8'h21;
	localparam logic [7:0] ADDR_RESULT_HI  = 8'h22;
	localparam logic [7:0] ADDR_RESULT_LO  = 8'h23;
	localparam logic [7:0] ADDR_REF_SEL    = 8'h24;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h28;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h29;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTL_ENABLE_BIT  = 7;
	localparam int CTL_START_BIT   = 6;
	localparam int CTL_CHAN_LSB    = 2;
	localparam int MODE_DIV_LSB    = 1;
	localparam int REF_EXT_BIT     = 7;
	localparam int IRQ_DONE_BIT    = 0;
	localparam int IRQ_IGNORED_BIT = 1;
	// ------------------------------------------------------------
	// reset values and codes
	// ------------------------------------------------------------
	localparam logic [3:0] CHAN_RESET    = 4'h0;
	localparam logic [3:0] CHAN_LAST_PIN = 4'hc;
	localparam logic [3:0] CHAN_BANDGAP  = 4'hf;
	localparam logic [2:0] DIV_RESET     = 3'h0;
	localparam logic [1:0] IRQ_RESET     = 2'h0;
	localparam int RESULT_BITS = 12;
	localparam int DIV_BITS    = 3;
	localparam int CONV_CLOCKS = 14;
	localparam int MUX_WIDTH   = 16;
endpackage
